// >>> include/ist_pkg.sv
// Package for the I2C slave data phase and bus time-out block
// Assumes a single 100 MHz clock and a plain strobed register port
package ist_pkg;

	// ****************************************
	// Register offsets (plain port, byte index)
	// ****************************************
	localparam logic [2:0] ADDR_DATA   = 3'h0; // i2c_data_buffer
	localparam logic [2:0] ADDR_OWN    = 3'h1; // own_slave_address_reg
	localparam logic [2:0] ADDR_CTRL0  = 3'h2; // serial_control_reg0
	localparam logic [2:0] ADDR_CTRL1  = 3'h3; // serial_control_reg1
	localparam logic [2:0] ADDR_TOC    = 3'h4; // timeout_control_reg

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int TOC_EN_BIT    = 7;
	localparam int TOC_FLAG_BIT  = 6;
	localparam int TOC_SEL_W     = 6;
	localparam int C1_MATCH_BIT  = 6;
	localparam int C1_BUSY_BIT   = 5;
	localparam int C1_TXMODE_BIT = 4;
	localparam int C1_ACKTX_BIT  = 3;
	localparam int C1_RW_BIT     = 2;
	localparam int C1_ACKRX_BIT  = 0;
	localparam logic [7:0] TOC_RST    = 8'h00;
	localparam logic [7:0] CTRL1_RST  = 8'h01;
	localparam logic [7:0] CTRL0_RST  = 8'h00;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;
	localparam int BYTE_BITS   = 8;
	localparam int ADDR_BITS   = 7;
	localparam int SUB_DIV     = 32;

	// ****************************************
	// Carriers and states
	// ****************************************
	typedef struct packed {
		logic scl;
		logic sda;
	} ist_bus_t;

	typedef struct packed {
		logic sda_oe;
		logic scl_oe;
	} ist_drv_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK,
		ST_STRETCH,
		ST_DATA,
		ST_WAIT
	} ist_state_t;

endpackage

// >>> logic/ist_timeout.sv
// Bus time-out counter ticking at subsidiary clock divided by 32
// Assumes sub_tick is a one-cycle enable at the subsidiary clock rate
`timescale 1ns/1ns
module ist_timeout #(
	parameter int SEL_W = 6,
	parameter int DIV   = 32
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             sub_tick,
	input  wire logic             run,
	input  wire logic             clear,
	input  wire logic [SEL_W-1:0] period_sel,
	output logic                  overflow
);
	localparam int DW = $clog2(DIV);
	logic [DW-1:0]  div_q;
	logic [SEL_W:0] cnt_q;
	wire            slow_tick = sub_tick && (div_q == DW'(DIV - 1));
	wire            expired   = slow_tick && (cnt_q == {1'b0, period_sel});

	// Divider and period counter, cleared on each SCL fall
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_q    <= '0;
			cnt_q    <= '0;
			overflow <= 1'b0;
		end else if (!run || clear) begin
			div_q    <= '0;
			cnt_q    <= '0;
			overflow <= 1'b0;
		end else begin
			if (sub_tick)
				div_q <= (div_q == DW'(DIV - 1)) ? '0 : div_q + 1'b1;
			if (slow_tick)
				cnt_q <= cnt_q + 1'b1;
			overflow <= expired;
		end
	end
endmodule

// >>> logic/ist_slave.sv
// I2C slave data phase, acknowledge, clock stretch and bus time-out
// Assumes SCL/SDA inputs are synchronous to clk; pins are open drain
//
// Contract
// - Data bytes are eight bits, exchanged after own address is acknowledged.
// - Data bits travel most significant first.
// - Receiver drives a low acknowledge after eight bits before next byte.
// - Transmitting slave releases SDA when the master gives no acknowledge.
// - Received bytes land in data buffer; transmit bytes come from it.
// - As receiver the slave drives ack_to_send on the ninth clock.
// - SCL held low after match until buffer write or dummy read.
// - Time-out counter starts on START plus match, cleared each SCL fall.
// - Time-out declared when time since last SCL fall exceeds selection.
// - STOP halts time-out counting.
// - Overflow stops counter, clears timeout_enable, sets timeout_flag.
// - Time-out raises the shared I2C interrupt request.
// - Time-out resets control register 1; other registers keep contents.
// - Software clears timeout_flag by writing zero.
// - Six-bit period select chooses one of sixty-four periods.
// - Counter runs at subsidiary clock over 32, (sel+1)*32 periods.
// - Address equal to own address sets address_matched and interrupts.
// - ack_to_send zero acknowledges, one does not.
// - ack_received reads zero when acknowledge sampled on ninth clock.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module ist_slave (
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire logic            sub_tick,
	input  wire ist_pkg::ist_bus_t bus_in,
	output ist_pkg::ist_drv_t    bus_drv,
	input  wire logic [2:0]      reg_addr,
	input  wire logic [7:0]      reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic [7:0]           reg_rdata,
	output logic                 irq
);
	// ****************************************
	// State and registers
	// ****************************************
	ist_pkg::ist_state_t st_q;
	logic [7:0] data_q, own_q, c0_q, shift_q, rdata_q;
	logic       match_q, busy_q, txm_q, ackt_q, rw_q, ackr_q;
	logic       toen_q, tof_q, irq_q, sda_oe_q, scl_oe_q;
	logic [5:0] tosel_q;
	logic [3:0] bit_q;
	logic       scl_p_q, sda_p_q, is_addr_q, tx_q;
	logic       to_ovf_raw;

	// ****************************************
	// Bus event decode
	// ****************************************
	wire scl_rise  = bus_in.scl && !scl_p_q;
	wire scl_fall  = !bus_in.scl && scl_p_q;
	wire start_ev  = bus_in.scl && scl_p_q && sda_p_q && !bus_in.sda;
	wire stop_ev   = bus_in.scl && scl_p_q && !sda_p_q && bus_in.sda;
	wire last_bit  = (bit_q == 4'(ist_pkg::BYTE_BITS - 1));
	wire addr_hit  = (shift_q[ist_pkg::ADDR_BITS-1:0] == own_q[ist_pkg::ADDR_BITS:1]) &&
	                 is_addr_q;
	wire wr_data   = reg_wr && (reg_addr == ist_pkg::ADDR_DATA);
	wire rd_data   = reg_rd && (reg_addr == ist_pkg::ADDR_DATA);
	wire wr_toc    = reg_wr && (reg_addr == ist_pkg::ADDR_TOC);
	wire to_run    = toen_q && busy_q && match_q;
	wire to_ovf    = to_ovf_raw && to_run;
	wire [7:0] c1_val = {1'b0, match_q, busy_q, txm_q, ackt_q, rw_q, 1'b0, ackr_q};
	wire [7:0] toc_val = {toen_q, tof_q, tosel_q};

	// ****************************************
	// Read mux
	// ****************************************
	logic [7:0] rd_mux;
	assign rd_mux = (reg_addr == ist_pkg::ADDR_DATA)  ? data_q :
	                (reg_addr == ist_pkg::ADDR_OWN)   ? own_q  :
	                (reg_addr == ist_pkg::ADDR_CTRL0) ? c0_q   :
	                (reg_addr == ist_pkg::ADDR_CTRL1) ? c1_val :
	                (reg_addr == ist_pkg::ADDR_TOC)   ? toc_val : ist_pkg::BYTE_ZERO;

	// Read data one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rdata_q <= ist_pkg::BYTE_ZERO;
		else
			rdata_q <= reg_rd ? rd_mux : ist_pkg::BYTE_ZERO;
	end
	assign reg_rdata = rdata_q;

	// ****************************************
	// Time-out counter
	// ****************************************
	ist_timeout #(
		.SEL_W (ist_pkg::TOC_SEL_W),
		.DIV   (ist_pkg::SUB_DIV)
	) u_to (
		.clk        (clk),
		.resetn     (resetn),
		.sub_tick   (sub_tick),
		.run        (to_run),
		.clear      (scl_fall),
		.period_sel (tosel_q),
		.overflow   (to_ovf_raw)
	);

	// Time-out control register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			toen_q  <= ist_pkg::TOC_RST[ist_pkg::TOC_EN_BIT];
			tof_q   <= ist_pkg::TOC_RST[ist_pkg::TOC_FLAG_BIT];
			tosel_q <= ist_pkg::TOC_RST[ist_pkg::TOC_SEL_W-1:0];
		end else begin
			if (wr_toc) begin
				toen_q  <= reg_wdata[ist_pkg::TOC_EN_BIT];
				tof_q   <= reg_wdata[ist_pkg::TOC_FLAG_BIT];
				tosel_q <= reg_wdata[ist_pkg::TOC_SEL_W-1:0];
			end
			if (to_ovf) begin
				toen_q <= 1'b0;
				tof_q  <= 1'b1;
			end
		end
	end

	// Plain software registers kept through a time-out
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			own_q <= ist_pkg::BYTE_ZERO;
			c0_q  <= ist_pkg::CTRL0_RST;
		end else if (reg_wr) begin
			if (reg_addr == ist_pkg::ADDR_OWN)
				own_q <= reg_wdata;
			if (reg_addr == ist_pkg::ADDR_CTRL0)
				c0_q <= reg_wdata;
		end
	end

	// ****************************************
	// Byte engine and control register 1
	// ****************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q      <= ist_pkg::ST_IDLE;
			data_q    <= ist_pkg::BYTE_ZERO;
			shift_q   <= ist_pkg::BYTE_ZERO;
			bit_q     <= '0;
			{match_q, busy_q, txm_q, ackt_q, rw_q} <= 5'h00;
			ackr_q    <= ist_pkg::CTRL1_RST[ist_pkg::C1_ACKRX_BIT];
			sda_oe_q  <= 1'b0;
			scl_oe_q  <= 1'b0;
			irq_q     <= 1'b0;
			scl_p_q   <= 1'b1;
			sda_p_q   <= 1'b1;
			is_addr_q <= 1'b0;
			tx_q      <= 1'b0;
		end else begin
			scl_p_q <= bus_in.scl;
			sda_p_q <= bus_in.sda;
			irq_q   <= 1'b0;
			if (wr_data)
				data_q <= reg_wdata;
			if (reg_wr && reg_addr == ist_pkg::ADDR_CTRL1) begin
				txm_q  <= reg_wdata[ist_pkg::C1_TXMODE_BIT];
				ackt_q <= reg_wdata[ist_pkg::C1_ACKTX_BIT];
			end
			if (to_ovf) begin
				st_q     <= ist_pkg::ST_IDLE;
				{match_q, busy_q, txm_q, ackt_q, rw_q} <= 5'h00;
				ackr_q   <= ist_pkg::CTRL1_RST[ist_pkg::C1_ACKRX_BIT];
				sda_oe_q <= 1'b0;
				scl_oe_q <= 1'b0;
				tx_q     <= 1'b0;
				irq_q    <= 1'b1;
			end else if (stop_ev) begin
				st_q     <= ist_pkg::ST_IDLE;
				busy_q   <= 1'b0;
				match_q  <= 1'b0;
				sda_oe_q <= 1'b0;
				scl_oe_q <= 1'b0;
				tx_q     <= 1'b0;
			end else if (start_ev) begin
				st_q      <= ist_pkg::ST_ADDR;
				busy_q    <= 1'b1;
				match_q   <= 1'b0;
				is_addr_q <= 1'b1;
				bit_q     <= '0;
				sda_oe_q  <= 1'b0;
				tx_q      <= 1'b0; // Address is always received
			end else begin
				unique case (st_q)
					ist_pkg::ST_IDLE: begin
						sda_oe_q <= 1'b0;
					end
					ist_pkg::ST_ADDR, ist_pkg::ST_DATA: begin
						if (scl_rise && !tx_q) begin
							shift_q <= {shift_q[6:0], bus_in.sda};
							bit_q   <= bit_q + 1'b1;
							if (last_bit) begin
								if (is_addr_q) begin
									if (addr_hit)
										rw_q <= bus_in.sda;
									match_q <= addr_hit;
									irq_q   <= addr_hit;
								end else begin
									data_q <= {shift_q[6:0], bus_in.sda};
									irq_q  <= 1'b1;
								end
								st_q <= (is_addr_q && !addr_hit) ? ist_pkg::ST_WAIT
								                                 : ist_pkg::ST_ACK;
							end
						end else if (scl_rise && tx_q) begin
							bit_q <= bit_q + 1'b1;
							if (last_bit)
								st_q <= ist_pkg::ST_ACK;
						end else if (scl_fall && tx_q) begin
							sda_oe_q <= !shift_q[7];
							shift_q  <= {shift_q[6:0], 1'b0};
						end
					end
					ist_pkg::ST_ACK: begin
						if (scl_fall && !tx_q && bit_q == 4'(ist_pkg::BYTE_BITS))
							sda_oe_q <= is_addr_q ? 1'b1 : !ackt_q;
						else if (scl_fall && tx_q)
							sda_oe_q <= 1'b0;
						if (scl_rise) begin
							bit_q <= '0;
							if (tx_q && !is_addr_q) begin
								ackr_q <= bus_in.sda;
								irq_q  <= 1'b1;
							end
						end
						if (scl_fall && bit_q == '0) begin
							sda_oe_q  <= 1'b0;
							scl_oe_q  <= !(tx_q && ackr_q);
							if (is_addr_q)
								tx_q <= rw_q;
							is_addr_q <= 1'b0;
							st_q <= (tx_q && ackr_q && !is_addr_q) ? ist_pkg::ST_WAIT
							                                       : ist_pkg::ST_STRETCH;
						end
					end
					ist_pkg::ST_STRETCH: begin
						if ((tx_q && wr_data) || (!tx_q && rd_data)) begin
							scl_oe_q <= 1'b0;
							shift_q  <= tx_q ? {reg_wdata[6:0], 1'b0} : shift_q;
							sda_oe_q <= tx_q && !reg_wdata[7];
							bit_q    <= '0;
							st_q     <= ist_pkg::ST_DATA;
						end
					end
					ist_pkg::ST_WAIT: begin
						sda_oe_q <= 1'b0;
					end
					default: st_q <= ist_pkg::ST_IDLE;
				endcase
			end
		end
	end

	assign bus_drv = '{sda_oe: sda_oe_q, scl_oe: scl_oe_q};
	assign irq            = irq_q;

	// ****************************************
	// Checks
	// ****************************************
	property p_to_clears_en;
		@(posedge clk) disable iff (!resetn) to_ovf |=> !toen_q && tof_q;
	endproperty
	a_to_clears_en: assert property (p_to_clears_en) else $error("enable not cleared");

	property p_to_irq;
		@(posedge clk) disable iff (!resetn) to_ovf |=> irq;
	endproperty
	a_to_irq: assert property (p_to_irq) else $error("no irq on time-out");

	property p_to_reset_c1;
		@(posedge clk) disable iff (!resetn) to_ovf |=> !match_q && !scl_oe_q;
	endproperty
	a_to_reset_c1: assert property (p_to_reset_c1) else $error("ctrl1 kept");

	property p_no_to_disabled;
		@(posedge clk) disable iff (!resetn) !toen_q && !wr_toc |=> $stable(tof_q);
	endproperty
	a_no_to_disabled: assert property (p_no_to_disabled) else $error("time-out while off");

	property p_stop_halts;
		@(posedge clk) disable iff (!resetn) stop_ev ##1 !start_ev |=> !to_ovf;
	endproperty
	a_stop_halts: assert property (p_stop_halts) else $error("count after stop");

	property p_flag_clear;
		@(posedge clk) disable iff (!resetn)
			wr_toc && !reg_wdata[ist_pkg::TOC_FLAG_BIT] && !to_ovf |=> !tof_q;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_release_stretch;
		@(posedge clk) disable iff (!resetn)
			st_q == ist_pkg::ST_STRETCH && !tx_q && rd_data && !to_ovf && !stop_ev
			&& !start_ev |=> !scl_oe_q;
	endproperty
	a_release_stretch: assert property (p_release_stretch) else $error("SCL stuck");

	property p_nack_release;
		@(posedge clk) disable iff (!resetn) st_q == ist_pkg::ST_WAIT |=> !sda_oe_q;
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("SDA held");

	property p_rdata;
		@(posedge clk) disable iff (!resetn)
			reg_rd && reg_addr == ist_pkg::ADDR_TOC |=> reg_rdata == $past(toc_val);
	endproperty
	a_rdata: assert property (p_rdata) else $error("bad toc read");

	property p_tx_msb_first;
		@(posedge clk) disable iff (!resetn)
			st_q == ist_pkg::ST_STRETCH && tx_q && wr_data && !to_ovf && !stop_ev && !start_ev
			|=> sda_oe_q == !$past(reg_wdata[ist_pkg::BYTE_BITS-1]);
	endproperty
	a_tx_msb_first: assert property (p_tx_msb_first) else $error("MSB not driven");

	property p_addr_ack;
		@(posedge clk) disable iff (!resetn)
			st_q == ist_pkg::ST_ACK && is_addr_q && scl_fall && bit_q == 4'(ist_pkg::BYTE_BITS)
			&& !to_ovf && !stop_ev && !start_ev |=> sda_oe_q;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

	property p_ack_drive;
		@(posedge clk) disable iff (!resetn)
			st_q == ist_pkg::ST_ACK && !is_addr_q && !tx_q && scl_fall
			&& bit_q == 4'(ist_pkg::BYTE_BITS) && !to_ovf && !stop_ev && !start_ev
			|=> sda_oe_q == !$past(ackt_q);
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("wrong ack level");

	property p_tx_nack_wait;
		@(posedge clk) disable iff (!resetn)
			st_q == ist_pkg::ST_ACK && tx_q && !is_addr_q && scl_fall && bit_q == '0
			&& ackr_q && !to_ovf && !stop_ev && !start_ev
			|=> st_q == ist_pkg::ST_WAIT && !scl_oe_q && !sda_oe_q;
	endproperty
	a_tx_nack_wait: assert property (p_tx_nack_wait) else $error("bus kept after nack");

	// Main scenarios reached
	c_timeout: cover property (@(posedge clk) disable iff (!resetn) to_ovf);
	c_tx_start: cover property (@(posedge clk) disable iff (!resetn)
		st_q == ist_pkg::ST_STRETCH && tx_q ##1 st_q == ist_pkg::ST_DATA);
	c_match: cover property (@(posedge clk) disable iff (!resetn) !match_q ##1 match_q);
	c_stretch: cover property (@(posedge clk) disable iff (!resetn)
		st_q == ist_pkg::ST_STRETCH ##1 st_q == ist_pkg::ST_DATA);
	c_nack: cover property (@(posedge clk) disable iff (!resetn) st_q == ist_pkg::ST_WAIT);
endmodule

// >>> tb/ist_master_model.sv
// Behavioural I2C bus master with pull-ups on SCL and SDA
// Assumes the slave only pulls lines low through its output enables
`timescale 1ns/1ns
module ist_master_model (
	input  wire ist_pkg::ist_drv_t drv,
	input  wire logic              clk,
	output ist_pkg::ist_bus_t      bus
);
	// ****************************************
	// Wired-AND lines, released lines float high
	// ****************************************
	logic scl_m = 1'b1;
	logic sda_m = 1'b1;
	logic hang  = 1'b0;
	assign bus = '{scl: scl_m & ~drv.scl_oe, sda: sda_m & ~drv.sda_oe};

	// Start: SDA falls while SCL is high
	task automatic start();
		sda_m <= 1'b1;
		scl_m <= 1'b1;
		repeat (4) @(posedge clk);
		sda_m <= 1'b0;
		repeat (4) @(posedge clk);
		scl_m <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	// Stop: SDA rises while SCL is high
	task automatic stop();
		sda_m <= 1'b0;
		repeat (4) @(posedge clk);
		scl_m <= 1'b1;
		repeat (4) @(posedge clk);
		sda_m <= 1'b1;
		repeat (4) @(posedge clk);
	endtask

	// One clock; waits out a stretched SCL under a bound
	task automatic clk_bit(input logic b, output logic r);
		int n;
		n = 0;
		sda_m <= b;
		repeat (4) @(posedge clk);
		scl_m <= 1'b1;
		while (bus.scl !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n == 400) hang = 1'b1;
		repeat (4) @(posedge clk);
		r = bus.sda;
		scl_m <= 1'b0;
		@(posedge clk);
	endtask

	// Eight bits then the acknowledge clock; ack low acknowledges a read
	task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(ack, a);
	endtask
endmodule

// >>> tb/ist_slave_tb.sv
// Self-checking bench for the I2C slave data phase and time-out block
// Assumes the master model drives the bus and sub_tick pulses every fourth clock
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module ist_slave_tb;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic              clk, resetn, sub_tick, reg_wr, reg_rd, irq, a;
	logic [2:0]        reg_addr;
	logic [7:0]        reg_wdata, reg_rdata, d, q, own, tsel;
	logic [7:0]        exp_q[$];
	ist_pkg::ist_bus_t bus_in;
	ist_pkg::ist_drv_t bus_drv;
	int                fails, cmp_count, irq_n, ticks, k, n, t0;

	ist_slave ist_slave_inst (.clk(clk), .resetn(resetn), .sub_tick(sub_tick),
		.bus_in(bus_in), .bus_drv(bus_drv), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	ist_master_model ist_master_model_inst (.drv(bus_drv), .clk(clk), .bus(bus_in));

	// Clock, subsidiary tick and event counters
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		k <= (k + 1) % 4;
		sub_tick <= (k == 3);
		if (irq === 1'b1) irq_n <= irq_n + 1;
		if (sub_tick === 1'b1) ticks <= ticks + 1;
	end

	// ****************************************
	// Register port tasks and closing report
	// ****************************************
	task automatic wr(input logic [2:0] ad, input logic [7:0] wd);
		reg_addr <= ad;
		reg_wdata <= wd;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [2:0] ad, output logic [7:0] rdat);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 rdat = reg_rdata;
		@(posedge clk);
	endtask
	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic wait_irq(input int lim);
		int m;
		m = 0;
		while (irq !== 1'b1 && m < lim) begin
			@(posedge clk);
			m++;
		end
		if (irq !== 1'b1) begin
			$display("[FAIL] %0t no interrupt in time", $time);
			fails++;
			print_verdict();
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{resetn, sub_tick, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		k = 0; fails = 0; cmp_count = 0; irq_n = 0; ticks = 0;
		n = $urandom(32'h79f5);
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		// Reset values and an unmapped index
		rd(ist_pkg::ADDR_TOC, d);
		`CHK(d, ist_pkg::TOC_RST)
		rd(ist_pkg::ADDR_CTRL1, d);
		`CHK(d, ist_pkg::CTRL1_RST)
		rd(3'h7, d);
		`CHK(d, 8'h00)
		$display("reset test done");
		// Receive: address, then an acknowledged and a refused byte
		own = 8'($urandom_range(127, 8) << 1);
		wr(ist_pkg::ADDR_OWN, own);
		ist_master_model_inst.start();
		n = irq_n;
		ist_master_model_inst.xfer(own, 1'b1, q, a);
		`CHK(a, 1'b0)
		`CHK(irq_n > n, 1'b1)
		rd(ist_pkg::ADDR_CTRL1, d);
		`CHK(d[ist_pkg::C1_MATCH_BIT], 1'b1)
		`CHK(bus_drv.scl_oe, 1'b1)
		rd(ist_pkg::ADDR_DATA, d);
		@(posedge clk);
		`CHK(bus_drv.scl_oe, 1'b0)
		for (int i = 0; i < 2; i++) begin
			wr(ist_pkg::ADDR_CTRL1, i ? 8'h08 : 8'h00);
			exp_q.push_back(8'($urandom));
			ist_master_model_inst.xfer(exp_q[0], 1'b1, q, a);
			`CHK(a, i[0])
			rd(ist_pkg::ADDR_DATA, q);
			d = exp_q.pop_front();
			`CHK(q, d)
		end
		ist_master_model_inst.stop();
		wr(ist_pkg::ADDR_TOC, 8'h80);
		n = irq_n;
		repeat (600) @(posedge clk);
		`CHK(irq_n, n)
		wr(ist_pkg::ADDR_TOC, 8'h00);
		$display("receive test done");
		// Transmit: master acknowledges one byte, refuses the next
		ist_master_model_inst.start();
		ist_master_model_inst.xfer(own | 8'h01, 1'b1, q, a);
		`CHK(a, 1'b0)
		wr(ist_pkg::ADDR_CTRL1, 8'h10);
		for (int i = 0; i < 2; i++) begin
			exp_q.push_back(8'($urandom));
			wr(ist_pkg::ADDR_DATA, exp_q[0]);
			ist_master_model_inst.xfer(8'hff, i[0], q, a);
			d = exp_q.pop_front();
			`CHK(q, d)
			rd(ist_pkg::ADDR_CTRL1, q);
			`CHK(q[ist_pkg::C1_ACKRX_BIT], i[0])
		end
		`CHK(bus_drv.sda_oe, 1'b0)
		ist_master_model_inst.stop();
		$display("transmit test done");
		// Stall under stretch: disabled, then enabled time-out
		ist_master_model_inst.start();
		ist_master_model_inst.xfer(own, 1'b1, q, a);
		n = irq_n;
		repeat (600) @(posedge clk);
		`CHK(irq_n, n)
		tsel = 8'($urandom_range(7, 0));
		wr(ist_pkg::ADDR_TOC, {2'b10, tsel[5:0]});
		t0 = ticks;
		n = (tsel + 1) * ist_pkg::SUB_DIV;
		wait_irq(n * 4 + 40);
		`CHK((ticks - t0 - n) * (ticks - t0 - n) <= 1, 1'b1)
		rd(ist_pkg::ADDR_TOC, q);
		`CHK(q, {2'b01, tsel[5:0]})
		rd(ist_pkg::ADDR_CTRL1, q);
		`CHK(q, ist_pkg::CTRL1_RST)
		rd(ist_pkg::ADDR_OWN, q);
		`CHK(q, own)
		rd(ist_pkg::ADDR_DATA, q);
		`CHK(q, d)
		`CHK(bus_drv.scl_oe, 1'b0)
		wr(ist_pkg::ADDR_TOC, {2'b00, tsel[5:0]});
		rd(ist_pkg::ADDR_TOC, q);
		`CHK(q, {2'b00, tsel[5:0]})
		`CHK(ist_master_model_inst.hang, 1'b0)
		$display("time-out test done");
		print_verdict();
	end
endmodule
